// [lsb_top.sv]
// Contract
// - Three groups of eight, 128 steps each.
// - Code 7Fh gives full-scale current.
// - Group current spans 0% to 100%.
// - Current equals full scale times code/127.
// - Code change acts on current at once.
// - Shift register and latches start undefined.
// - Blank low: outputs follow on/off bits. Here a set soft blank bit in REG_CTRL still forces them all off.
// - Bit one on, bit zero off.
// - Blank high forces all outputs off.
// - Select zero: strobe loads on/off latch.
// - Select one: strobe loads control latch.
// - Red 6:0, green 13:7, blue 20:14.
// - Shift register 25 bits, top selects.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
module lsb_top
    import lsb_pkg::*;
(
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic [2:0] s_axi_awprot, // Write protection, unused.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [DATA_W-1:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic [2:0] s_axi_arprot, // Read protection, unused.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [DATA_W-1:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic serial_clk_in, // Serial shift clock, sampled.
    input wire logic serial_data_in, // Serial data.
    input wire logic latch_strobe, // Latch strobe, rising edge acts.
    input wire logic blank, // Blanking input, high forces off.
    input wire logic [CUR_W-1:0] full_scale_sink_current, // Full-scale current.
    output logic [GROUP_N-1:0] red_sink_channel, // Red channel enables.
    output logic [GROUP_N-1:0] green_sink_channel, // Green channel enables.
    output logic [GROUP_N-1:0] blue_sink_channel, // Blue channel enables.
    output logic [CODE_W-1:0] red_brightness_code, // Red group code.
    output logic [CODE_W-1:0] green_brightness_code, // Green group code.
    output logic [CODE_W-1:0] blue_brightness_code, // Blue group code.
    output logic [CUR_W-1:0] red_group_current, // Red group current.
    output logic [CUR_W-1:0] green_group_current, // Green group current.
    output logic [CUR_W-1:0] blue_group_current // Blue group current.
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [SHIFT_W-1:0] shift_q;
    logic [LATCH_W-1:0] onoff_q;
    logic [LATCH_W-1:0] ctrl_latch_q;
    logic soft_blank_q;
    logic sclk_prev_q;
    logic strobe_prev_q;
    logic sclk_rise;
    logic strobe_rise;

    // Write channel.
    lsb_wr_state_t wr_state_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [1:0] bresp_q;

    // Read channel.
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic rvalid_q;

    lsb_drive_if drv ();

    // Write byte lanes into an existing word.
    function automatic logic [DATA_W-1:0] lsb_merge(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] val,
                                                    input logic [3:0] strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = val[i*8 +: 8];
        end
        return res;
    endfunction

    // True for a mapped register offset.
    function automatic logic lsb_mapped(input logic [ADDR_W-1:0] a);
        return (a == REG_CTRL) || (a == REG_SHIFT) || (a == REG_ONOFF) ||
            (a == REG_BRIGHT) || (a == REG_ENABLE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on the serial pins.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sclk_prev_q <= 1'b0;
            strobe_prev_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= serial_clk_in;
            strobe_prev_q <= latch_strobe;
        end
    end

    assign sclk_rise = serial_clk_in & ~sclk_prev_q;
    assign strobe_rise = latch_strobe & ~strobe_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Shift register: serial bits enter at the bottom; a bus write wins.
    // It is left without reset so its content is undefined until written.
    always_ff @(posedge aclk)
    begin
        if (wr_fire && awaddr_q == REG_SHIFT)
            shift_q <= SHIFT_W'(lsb_merge(DATA_W'(shift_q), wdata_q, wstrb_q));
        else if (sclk_rise)
            shift_q <= {shift_q[SHIFT_W-2:0], serial_data_in};
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch transfer: the top bit steers the payload to one latch.
    // Neither latch is reset, so each holds garbage until loaded.
    always_ff @(posedge aclk)
    begin
        if (strobe_rise && !shift_q[SEL_BIT])
            onoff_q <= shift_q[LATCH_W-1:0];
    end

    always_ff @(posedge aclk)
    begin
        if (strobe_rise && shift_q[SEL_BIT])
            ctrl_latch_q <= shift_q[LATCH_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Software blank forcing, ORed with the pin.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            soft_blank_q <= CTRL_RST;
        else if (wr_fire && awaddr_q == REG_CTRL && wstrb_q[0])
            soft_blank_q <= wdata_q[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Hand latch contents to the output stage, codes unchanged.
    assign drv.onoff = onoff_q;
    assign drv.red_code = ctrl_latch_q[RED_LSB +: CODE_W];
    assign drv.green_code = ctrl_latch_q[GREEN_LSB +: CODE_W];
    assign drv.blue_code = ctrl_latch_q[BLUE_LSB +: CODE_W];
    assign drv.blank = blank | soft_blank_q;
    assign drv.full_scale = full_scale_sink_current;

    lsb_output_stage u_stage (
        .aclk(aclk),
        .aresetn(aresetn),
        .drv(drv)
    );

    // Group outputs, eight channels each.
    assign red_sink_channel = drv.enable[RED_CH_LSB +: GROUP_N];
    assign green_sink_channel = drv.enable[GREEN_CH_LSB +: GROUP_N];
    assign blue_sink_channel = drv.enable[BLUE_CH_LSB +: GROUP_N];
    assign red_brightness_code = drv.red_code;
    assign green_brightness_code = drv.green_code;
    assign blue_brightness_code = drv.blue_code;
    assign red_group_current = drv.red_cur;
    assign green_group_current = drv.green_cur;
    assign blue_group_current = drv.blue_cur;

    ////////////////////////////////////////////////////////////////////////
    // Write address and data are captured in either order.
    assign s_axi_awready = (wr_state_q == WR_IDLE) && !aw_held_q;
    assign s_axi_wready = (wr_state_q == WR_IDLE) && !w_held_q;
    assign wr_fire = (wr_state_q == WR_IDLE) && aw_held_q && w_held_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held_q <= 1'b0;
    end

    // Response state: one write at a time.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_q <= WR_IDLE;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            case (wr_state_q)
                WR_IDLE:
                begin
                    if (wr_fire)
                    begin
                        wr_state_q <= WR_RESP;
                        bresp_q <= lsb_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP:
                begin
                    if (s_axi_bready)
                        wr_state_q <= WR_IDLE;
                end
                default: wr_state_q <= WR_IDLE;
            endcase
        end
    end

    assign s_axi_bvalid = (wr_state_q == WR_RESP);
    assign s_axi_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Read channel: data registered one cycle after the address.
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL: rdata_q <= DATA_W'(soft_blank_q);
                REG_SHIFT: rdata_q <= DATA_W'(shift_q);
                REG_ONOFF: rdata_q <= DATA_W'(onoff_q);
                REG_BRIGHT: rdata_q <= DATA_W'(ctrl_latch_q);
                REG_ENABLE: rdata_q <= DATA_W'(drv.enable);
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// [lsb_pkg.sv]
package lsb_pkg;

    // Bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Shift register and latch geometry.
    localparam int SHIFT_W = 25;
    localparam int LATCH_W = 24;
    localparam int SEL_BIT = 24;
    localparam int GROUP_N = 8;
    localparam int CODE_W = 7;
    localparam int CUR_W = 16;

    // Brightness field positions inside the control latch.
    localparam int RED_LSB = 0;
    localparam int GREEN_LSB = 7;
    localparam int BLUE_LSB = 14;

    // Channel field positions inside the on/off latch.
    localparam int RED_CH_LSB = 0;
    localparam int GREEN_CH_LSB = 8;
    localparam int BLUE_CH_LSB = 16;

    // Full-scale code and its divisor.
    localparam logic [6:0] CODE_MAX = 7'h7F;
    localparam logic [6:0] CODE_DIV = 7'h7F;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SHIFT = 8'h04;
    localparam logic [7:0] REG_ONOFF = 8'h08;
    localparam logic [7:0] REG_BRIGHT = 8'h0C;
    localparam logic [7:0] REG_ENABLE = 8'h10;

    // Reset values.
    localparam logic CTRL_RST = 1'h0;
    localparam logic [CUR_W-1:0] CUR_RST = 16'h0000;
    localparam logic [LATCH_W-1:0] EN_RST = 24'h000000;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write channel states.
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } lsb_wr_state_t;

endpackage

// [lsb_drive_if.sv]
interface lsb_drive_if;
    import lsb_pkg::*;

    logic [LATCH_W-1:0] onoff;
    logic [CODE_W-1:0] red_code;
    logic [CODE_W-1:0] green_code;
    logic [CODE_W-1:0] blue_code;
    logic blank;
    logic [CUR_W-1:0] full_scale;
    logic [LATCH_W-1:0] enable;
    logic [CUR_W-1:0] red_cur;
    logic [CUR_W-1:0] green_cur;
    logic [CUR_W-1:0] blue_cur;

    // The core drives latch contents and blanking, the stage returns drive values.
    modport core (
        output onoff, red_code, green_code, blue_code, blank, full_scale,
        input enable, red_cur, green_cur, blue_cur
    );
    modport stage (
        input onoff, red_code, green_code, blue_code, blank, full_scale,
        output enable, red_cur, green_cur, blue_cur
    );

endinterface

// [lsb_output_stage.sv]
module lsb_output_stage
    import lsb_pkg::*;
(
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Synchronous reset, active low.
    lsb_drive_if.stage drv // Latch contents in, drive values out.
);

    // Scales a full-scale current by code over 127.
    function automatic logic [CUR_W-1:0] lsb_scale(input logic [CUR_W-1:0] fs,
                                                   input logic [CODE_W-1:0] code);
        logic [22:0] prod;
        prod = 23'(fs) * 23'(code);
        return CUR_W'(prod / 23'(CODE_DIV));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Each channel is on only when its bit is set and blanking is low.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            drv.enable <= EN_RST;
        else
            drv.enable <= drv.onoff & {LATCH_W{~drv.blank}};
    end

    ////////////////////////////////////////////////////////////////////////
    // Each group current follows its own code with no further event.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drv.red_cur <= CUR_RST;
            drv.green_cur <= CUR_RST;
            drv.blue_cur <= CUR_RST;
        end
        else
        begin
            drv.red_cur <= lsb_scale(drv.full_scale, drv.red_code);
            drv.green_cur <= lsb_scale(drv.full_scale, drv.green_code);
            drv.blue_cur <= lsb_scale(drv.full_scale, drv.blue_code);
        end
    end

endmodule

// [lsb_host.sv]
module lsb_host (
    input logic aclk, // Clock.
    output logic serial_clk_in, // Shift clock, still between frames.
    output logic serial_data_in, // Serial data.
    output logic latch_strobe, // Latch strobe.
    output logic blank // Blanking level.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Power up blanked, so nothing lights before both latches are written.
    initial
    begin
        serial_clk_in = 1'b0;
        serial_data_in = 1'b0;
        latch_strobe = 1'b0;
        blank = 1'b1;
    end

    // Shifts one word, select bit first, then strobes it into a latch.
    task automatic send(input logic [24:0] w);
        for (int i = 24; i >= 0; i--)
        begin
            @(posedge aclk);
            serial_data_in <= w[i];
            @(posedge aclk);
            serial_clk_in <= 1'b1;
            @(posedge aclk);
            serial_clk_in <= 1'b0;
        end
        @(posedge aclk);
        latch_strobe <= 1'b1;
        serial_data_in <= ~w[0]; // The released line must not keep the last bit.
        @(posedge aclk);
        latch_strobe <= 1'b0;
    endtask

    // Moves the blanking level just after a clock edge.
    task automatic set_blank(input logic v);
        @(posedge aclk);
        blank <= v;
    endtask
endmodule

// [lsb_top_sva.sv]
module lsb_top_sva
    import lsb_pkg::*;
(
    input logic aclk, // Clock.
    input logic aresetn, // Reset.
    input logic s_axi_awvalid, // Address valid.
    input logic s_axi_awready, // Address ready.
    input logic s_axi_wvalid, // Data valid.
    input logic s_axi_wready, // Data ready.
    input logic s_axi_bvalid, // Response valid.
    input logic serial_clk_in, // Shift clock.
    input logic serial_data_in, // Serial data.
    input logic latch_strobe, // Strobe.
    input logic blank, // Blanking.
    input logic [CUR_W-1:0] full_scale_sink_current, // Full scale.
    input logic [GROUP_N-1:0] red_sink_channel, // Red enables.
    input logic [GROUP_N-1:0] green_sink_channel, // Green enables.
    input logic [GROUP_N-1:0] blue_sink_channel, // Blue enables.
    input logic [CODE_W-1:0] red_brightness_code, // Red code.
    input logic [CODE_W-1:0] green_brightness_code, // Green code.
    input logic [CODE_W-1:0] blue_brightness_code, // Blue code.
    input logic [CUR_W-1:0] red_group_current, // Red current.
    input logic [CUR_W-1:0] green_group_current, // Green current.
    input logic [CUR_W-1:0] blue_group_current // Blue current.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic sclk_q, lat_q, ctl_ok_q, onoff_ok_q, lat_rise;
    logic [SHIFT_W-1:0] sh_q;
    logic [LATCH_W-1:0] onoff_q, en;
    logic [20:0] codes, codes_sh;
    logic [CUR_W-1:0] exp_r, exp_g, exp_b;

    // Views of the outputs and the expected currents for the codes now shown.
    assign lat_rise = latch_strobe && !lat_q;
    assign en = {blue_sink_channel, green_sink_channel, red_sink_channel};
    assign codes = {blue_brightness_code, green_brightness_code, red_brightness_code};
    assign codes_sh = sh_q[20:0];
    assign exp_r = CUR_W'((32'(full_scale_sink_current) * 32'(red_brightness_code)) / 127);
    assign exp_g = CUR_W'((32'(full_scale_sink_current) * 32'(green_brightness_code)) / 127);
    assign exp_b = CUR_W'((32'(full_scale_sink_current) * 32'(blue_brightness_code)) / 127);

    // Mirrors the shift register and the on/off latch from the serial pins.
    always_ff @(posedge aclk)
    begin
        sclk_q <= serial_clk_in;
        lat_q <= latch_strobe;
        if (serial_clk_in && !sclk_q)
            sh_q <= {sh_q[SHIFT_W-2:0], serial_data_in};
        if (lat_rise && !sh_q[SEL_BIT])
            onoff_q <= sh_q[LATCH_W-1:0];
    end

    // Marks which latch holds known data, so undefined contents are never judged.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_ok_q <= 1'b0;
            onoff_ok_q <= 1'b0;
        end
        else if (lat_rise)
        begin
            ctl_ok_q <= ctl_ok_q || sh_q[SEL_BIT];
            onoff_ok_q <= onoff_ok_q || !sh_q[SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ctl_load;
        lat_rise && sh_q[SEL_BIT];
    endsequence

    a_blank_off: assert property (blank |=> en == 24'h000000)
        else $error("channel enabled while blanked");
    a_enable_subset: assert property (onoff_ok_q |=> (en & ~$past(onoff_q)) == 24'h000000)
        else $error("channel enabled with its on/off bit clear");
    a_code_load: assert property (s_ctl_load |=> codes == $past(codes_sh))
        else $error("brightness codes not taken from the shift register");
    a_code_hold: assert property (ctl_ok_q && !(lat_rise && sh_q[SEL_BIT]) |=> $stable(codes))
        else $error("brightness codes changed without a control load");
    a_red_current: assert property (ctl_ok_q |=> red_group_current == $past(exp_r))
        else $error("red group current wrong");
    a_green_current: assert property (ctl_ok_q |=> green_group_current == $past(exp_g))
        else $error("green group current wrong");
    a_blue_current: assert property (ctl_ok_q |=> blue_group_current == $past(exp_b))
        else $error("blue group current wrong");
    a_write_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
endmodule

bind lsb_top lsb_top_sva i_lsb_top_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .serial_clk_in, .serial_data_in,
    .latch_strobe, .blank, .full_scale_sink_current, .red_sink_channel, .green_sink_channel,
    .blue_sink_channel, .red_brightness_code, .green_brightness_code, .blue_brightness_code,
    .red_group_current, .green_group_current, .blue_group_current);

// [lsb_top_tb_top.sv]
`define check_eq(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module lsb_top_tb_top
    import lsb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    int n_tests = 0;
    int mismatches = 0;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [DATA_W-1:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [CUR_W-1:0] full_scale_sink_current = 16'hFFFF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic serial_clk_in, serial_data_in, latch_strobe, blank;
    logic [GROUP_N-1:0] red_sink_channel, green_sink_channel, blue_sink_channel;
    logic [CODE_W-1:0] red_brightness_code, green_brightness_code, blue_brightness_code;
    logic [CUR_W-1:0] red_group_current, green_group_current, blue_group_current;
    logic [LATCH_W-1:0] en;

    assign en = {blue_sink_channel, green_sink_channel, red_sink_channel};

    // The clock, 25 ns period.
    always #12.5 aclk = ~aclk;

    lsb_top i_lsb_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .serial_clk_in, .serial_data_in, .latch_strobe, .blank,
        .full_scale_sink_current, .red_sink_channel, .green_sink_channel, .blue_sink_channel,
        .red_brightness_code, .green_brightness_code, .blue_brightness_code,
        .red_group_current, .green_group_current, .blue_group_current);
    lsb_host i_lsb_host (.aclk, .serial_clk_in, .serial_data_in, .latch_strobe, .blank);

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Lets registered outputs land before they are looked at.
    task automatic settle();
        repeat (2) @(negedge aclk);
    endtask

    // Expected group current for a code at the present full scale.
    function automatic logic [CUR_W-1:0] cur(input int c);
        return CUR_W'((32'(full_scale_sink_current) * c) / 127);
    endfunction

    // One write: address and data offered together, each released once taken.
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          output logic [1:0] r);
        logic aw, w;
        {aw, w} = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready)
                aw = 1'b0;
            if (s_axi_wready)
                w = 1'b0;
            {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    // One read: address released once taken, ready held until the data are sampled.
    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                          output logic [1:0] r);
        logic ar;
        ar = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready)
                ar = 1'b0;
            s_axi_arvalid <= ar;
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    // Every brightness code on each group while still blanked.
    task automatic t_codes();
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        logic [SHIFT_W-1:0] w;
        `check_eq(en, 24'h000000)
        for (int c = 0; c < 128; c++)
        begin
            w = {1'b1, 3'h0, 7'(c), 7'(127 - c), 7'(c)};
            i_lsb_host.send(w);
            // A new full scale each step, so the scaling is not judged at one value only.
            full_scale_sink_current <= 16'hFFFF - 16'(c);
            settle();
            `check_eq({blue_brightness_code, green_brightness_code, red_brightness_code}, w[20:0])
            `check_eq(red_group_current, cur(c))
            `check_eq(green_group_current, cur(127 - c))
            `check_eq(blue_group_current, cur(c))
        end
        axi_rd(REG_BRIGHT, d, r);
        `check_eq(d, {8'h00, w[23:0]})
        $display("t_codes done");
    endtask

    // On/off loads, pin and soft blanking, live reload with the low 16 bits flipped.
    task automatic t_onoff();
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        i_lsb_host.send({1'b0, 24'h005AC3});
        settle();
        `check_eq(en, 24'h000000)
        i_lsb_host.set_blank(1'b0);
        settle();
        `check_eq(en, 24'h005AC3)
        axi_wr(REG_CTRL, 32'h00000001, r);
        settle();
        `check_eq(en, 24'h000000)
        axi_wr(REG_CTRL, 32'h00000000, r);
        i_lsb_host.send({1'b0, 24'h00A53C});
        settle();
        `check_eq(en, 24'h00A53C)
        `check_eq(red_brightness_code, 7'h7F)
        axi_rd(REG_ENABLE, d, r);
        `check_eq(d, 32'h0000A53C)
        i_lsb_host.set_blank(1'b1);
        settle();
        `check_eq(en, 24'h000000)
        $display("t_onoff done");
    endtask

    // Register map: read-only place, unmapped address both ways.
    task automatic t_regs();
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        axi_rd(REG_CTRL, d, r);
        `check_eq(d, 32'h00000000)
        axi_wr(REG_ONOFF, 32'hFFFFFFFF, r);
        `check_eq(r, RESP_OKAY)
        axi_rd(REG_ONOFF, d, r);
        `check_eq(d, 32'h0000A53C)
        axi_wr(8'h40, 32'hFFFFFFFF, r);
        `check_eq(r, RESP_SLVERR)
        axi_rd(8'h40, d, r);
        `check_eq({d, r}, {32'h00000000, RESP_SLVERR})
        // A bus load of the shift register keeps only its 25 bits; no strobe follows it.
        axi_wr(REG_SHIFT, 32'hFF234567, r);
        axi_rd(REG_SHIFT, d, r);
        `check_eq(d, 32'h01234567)
        $display("t_regs done");
    endtask

    // Cuts a hang short.
    initial
    begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        test_done();
    end

    // Reset for three cycles, then the tests in turn.
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_codes();
        t_onoff();
        t_regs();
        test_done();
    end
endmodule
